// ### src/spc_map.svh
// Register indices, field positions, reset values and rate divisors
// for the serial port 0 control block.
// Assumes: included by bare name from the package only; the design modules use its macros from there.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Register indices; the APB byte address is four times the index
`define SPC_IDX_POWER_CONTROL 8'h87
`define SPC_IDX_SERIAL_CONTROL 8'h98
`define SPC_IDX_SERIAL_BUFFER 8'h99
`define SPC_IDX_SERIAL_CONFIG 8'h9C
`define SPC_IDX_AUX_CONTROL_TWO 8'hA3
`define SPC_IDX_STATION_ADDRESS 8'hA9
`define SPC_IDX_STATION_ADDRESS_MASK 8'hB9

// APB address width and unused read lanes
`define SPC_PADDR_W 12
`define SPC_RD_PAD 24'h00_0000

// Reset values
`define SPC_RST_POWER_CONTROL 8'h00
`define SPC_RST_SERIAL_CONTROL 8'h00
`define SPC_RST_SERIAL_CONFIG 8'h08
`define SPC_RST_AUX_CONTROL_TWO 8'h00
`define SPC_RST_STATION_ADDRESS 8'h00
`define SPC_RST_STATION_ADDRESS_MASK 8'h00
`define SPC_RST_SERIAL_BUFFER 8'h00

// power_control fields
`define SPC_PC_BAUD_DOUBLER 7
`define SPC_PC_FE_VIEW 6
// serial_control fields
`define SPC_SC_MODE_LOW 7
`define SPC_SC_MODE_MID 6
`define SPC_SC_ADDR_REC 5
`define SPC_SC_RX_EN 4
`define SPC_SC_TX_NINTH 3
`define SPC_SC_RX_NINTH 2
`define SPC_SC_TX_DONE 1
`define SPC_SC_RX_DONE 0
// serial_config fields
`define SPC_CF_ALT_TIMER 7
`define SPC_CF_EXTRA_DOUBLER 6
`define SPC_CF_SHIFT_RATE 5
`define SPC_CF_MODE_HIGH 4
`define SPC_CF_BIT_ORDER 3
`define SPC_CF_TX_IRQ_BLOCK 2
`define SPC_CF_TX_IRQ_SHARE 1
`define SPC_CF_RESERVED 0
// aux_control_two fields
`define SPC_AX_T1_FAST 3

// Operating modes {mode_select_high, mode_select_low, mode_select_mid}
`define SPC_MODE_SHIFT 3'd0
`define SPC_MODE_UART8 3'd1
`define SPC_MODE_UART9F 3'd2
`define SPC_MODE_UART9V 3'd3
`define SPC_MODE_SPI 3'd4

// Divisors; shift modes tick twice per bit, UART modes four times per bit
`define SPC_SHIFT_HALF_SLOW 5'd6
`define SPC_SHIFT_HALF_FAST 5'd2
`define SPC_MODE2_BASE 5'd16
`define SPC_MODE13_BASE 5'd8
`define SPC_SAMPLE_PHASE 2'd1
`define SPC_START_BIT 4'd0
`define SPC_LAST_DATA_BIT 4'd8
`define SPC_NINTH_BIT 4'd9
`define SPC_STOP9_BIT 4'd10
`define SPC_SYNC_LAST 4'd7

`endif

// ### src/spc_pkg.sv
// Types for the serial port 0 control block: engine states and the
// packed state records of both modules.
// Assumes: spc_map.svh is on the include path.
`include "spc_map.svh"

package spc_pkg;

  // Transmit / shift engine states
  typedef enum logic [1:0] {TX_IDLE, TX_UART, TX_SYNC} spc_tx_st_t;

  // UART receive engine states
  typedef enum logic {RX_IDLE, RX_BUSY} spc_rx_st_t;

  // All state of the control module
  typedef struct packed {
    logic [7:0] pcon;
    logic [7:0] scon;
    logic fe;
    logic [7:0] cfg;
    logic [7:0] aux;
    logic [7:0] station_address_mask;
    logic [7:0] station_address;
    logic [7:0] rxbuf;
    spc_tx_st_t tx_st;
    logic [10:0] tx_frame;
    logic [3:0] tx_bit;
    logic [1:0] tx_ph;
    logic sync_rx;
    spc_rx_st_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_bit;
    logic [1:0] rx_ph;
    logic rx_n9;
    logic txd;
    logic rxd_o;
    logic rxd_oe;
    logic ser_irq;
    logic sys_irq;
    logic t1_fast;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } spc_ctl_state_t;

  // All state of the rate generator
  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } spc_baud_state_t;

endpackage : spc_pkg

// ### src/spc_baud_gen.sv
// Rate generator: turns the system clock or a timer overflow into the
// engine tick (two per bit in shift modes, four per bit in UART modes).
// Assumes: overflow inputs are one-cycle pulses in the pclk domain.
`timescale 1ns/100ps

module spc_baud_gen
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Rate controls
  input wire logic [2:0] mode,
  input wire logic baud_doubler,
  input wire logic baud_extra_doubler,
  input wire logic shift_rate_select,
  input wire logic alt_baud_timer_select,
  // Timer overflow pulses
  input wire logic timer1_ovf,
  input wire logic alt_timer_ovf,
  // Engine tick, registered
  output logic tick
);

  spc_baud_state_t r_r; // Registered state
  spc_baud_state_t r_nxt; // Next state
  logic [1:0] dbl; // Doubling weight, extra doubler counts twice
  logic src; // Count enable from the selected source
  logic [4:0] div; // Ticks per engine tick

  // Divider and source select
  always_comb begin
    r_nxt = r_r;
    r_nxt.tick = 1'b0;
    dbl = {baud_extra_doubler, baud_doubler};
    if (mode == `SPC_MODE_UART8 || mode == `SPC_MODE_UART9V) begin
      src = alt_baud_timer_select ? alt_timer_ovf : timer1_ovf; // see R16
      div = `SPC_MODE13_BASE >> dbl; // see R15
    end else if (mode == `SPC_MODE_UART9F) begin
      src = 1'b1;
      div = `SPC_MODE2_BASE >> dbl; // see R18
    end else begin
      src = 1'b1;
      div = shift_rate_select ? `SPC_SHIFT_HALF_FAST : `SPC_SHIFT_HALF_SLOW; // see R17
    end
    // Compare with >= so a mode change to a shorter divisor cannot overrun
    if (src) begin
      if (r_r.cnt >= div - 5'd1) begin
        r_nxt.cnt = 5'd0;
        r_nxt.tick = 1'b1;
      end else begin
        r_nxt.cnt = r_r.cnt + 5'd1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign tick = r_r.tick;

endmodule : spc_baud_gen

// ### src/spc_serial_port0_control.sv
// Serial port 0 control: APB register file, shift/UART/SPI engines,
// framing error capture and automatic address recognition.
// Assumes: APB master on pclk; timer overflows are one-cycle pulses.
//
// Function
// R01 - Three mode bits select modes zero to four
// R02 - Invalid stop sets sticky framing error flag
// R03 - Framing error set regardless of view select
// R04 - Modes 2/3 address filter needs ninth bit
// R05 - Mode 1 address filter needs valid stop
// R06 - Reception only while receive enable set; SPI transfers load the buffer from MISO even with it clear
// R07 - Modes 2/3 send software ninth bit
// R08 - Store received ninth bit or stop bit
// R09 - Transmit flag timing per mode, software clears
// R10 - Receive flag timing per mode, software clears
// R11 - One buffer for transmit and receive data
// R12 - Given address masks don't-care bits
// R13 - Broadcast address is address OR mask
// R14 - Address and mask reset to zero
// R15 - Doubler bits double UART baud rate; the extra doubler alone quadruples it
// R16 - Alternate timer replaces timer 1 overflow
// R17 - Shift modes at clock over 12 or 4
// R18 - Mode 2 fixed fraction of clock
// R19 - Bit order select, resets to LSB first
// R20 - Block bit removes transmit flag from interrupt
// R21 - Share bit routes transmit flag to system
// R22 - Timer 1 fast clock output bit
`timescale 1ns/100ps

module spc_serial_port0_control
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SPC_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Baud sources
  input wire logic timer1_ovf,
  input wire logic alt_timer_ovf,
  // Serial pins
  output logic txd_o,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe,
  input wire logic miso_i,
  // Interrupt and timer controls
  output logic serial_irq,
  output logic sysflag_irq,
  output logic timer1_fast_clock
);

  spc_ctl_state_t r_r; // Registered state
  spc_ctl_state_t r_nxt; // Next state
  logic tick; // Engine tick from the rate generator
  logic [2:0] mode; // Decoded operating mode
  logic is_uart; // Modes 1 to 3
  logic is_nine; // Modes 2 and 3
  logic is_sync; // Modes 0 and 4
  logic lsb_first; // Bit order
  logic setup; // APB setup phase
  logic wr; // APB write taking effect
  logic [7:0] idx; // Register index
  logic aligned; // Address inside the map window
  logic [7:0] wd; // Write data byte
  logic [7:0] wd_rev; // Write data reversed
  logic [7:0] tx_ord; // Transmit byte in wire order
  logic [7:0] sh_new; // Receive shifter after one more bit
  logic smp; // Sampled serial input
  logic stop_ok; // Stop bit valid
  logic addr_hit; // Given or broadcast match
  logic accept; // Frame passes the address filter

  // Bit reversal for MSB-first transmission
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign wd_rev[gi] = pwdata[7 - gi];
    end
  endgenerate

  // Shared rate generator
  spc_baud_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode),
    .baud_doubler(r_r.pcon[`SPC_PC_BAUD_DOUBLER]),
    .baud_extra_doubler(r_r.cfg[`SPC_CF_EXTRA_DOUBLER]),
    .shift_rate_select(r_r.cfg[`SPC_CF_SHIFT_RATE]),
    .alt_baud_timer_select(r_r.cfg[`SPC_CF_ALT_TIMER]),
    .timer1_ovf(timer1_ovf),
    .alt_timer_ovf(alt_timer_ovf),
    .tick(tick)
  );

  // Mode decode and bus qualifiers
  always_comb begin
    mode = {r_r.cfg[`SPC_CF_MODE_HIGH], r_r.scon[`SPC_SC_MODE_LOW], r_r.scon[`SPC_SC_MODE_MID]}; // see R01
    is_uart = (mode == `SPC_MODE_UART8) || (mode == `SPC_MODE_UART9F) || (mode == `SPC_MODE_UART9V);
    is_nine = (mode == `SPC_MODE_UART9F) || (mode == `SPC_MODE_UART9V);
    is_sync = (mode == `SPC_MODE_SHIFT) || (mode == `SPC_MODE_SPI); // reserved modes stay idle
    lsb_first = r_r.cfg[`SPC_CF_BIT_ORDER];
    setup = psel && !penable;
    wr = psel && penable && r_r.pready && pwrite;
    idx = paddr[9:2];
    aligned = (paddr[`SPC_PADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
    wd = pwdata[7:0];
    tx_ord = lsb_first ? wd : wd_rev; // see R19
    // Sampled input: MISO in SPI mode, receive line otherwise
    smp = (mode == `SPC_MODE_SPI) ? miso_i : rxd_i;
    sh_new = lsb_first ? {smp, r_r.rx_sh[7:1]} : {r_r.rx_sh[6:0], smp}; // see R19
    stop_ok = rxd_i;
    // Zero mask bits are don't-care in the given address
    addr_hit = (((r_r.rx_sh ^ r_r.station_address) & r_r.station_address_mask) == 8'h00) // see R12
      // Ones of address OR mask must be ones in the byte
      || (((~r_r.rx_sh) & (r_r.station_address | r_r.station_address_mask)) == 8'h00); // see R13
    if (!r_r.scon[`SPC_SC_ADDR_REC]) begin
      accept = 1'b1;
    end else if (is_nine) begin
      accept = r_r.rx_n9 && addr_hit; // see R04
    end else begin
      accept = stop_ok && addr_hit; // see R05
    end
  end

  // Next state: bus first, then hardware events so that a set wins a clear
  always_comb begin
    r_nxt = r_r;
    r_nxt.pready = setup;
    r_nxt.pslverr = 1'b0;
    r_nxt.prdata = '0;

    // Read data and error are prepared in the setup phase
    if (setup) begin
      if (!aligned) begin
        r_nxt.pslverr = 1'b1;
      end else if (idx == `SPC_IDX_POWER_CONTROL) begin
        r_nxt.prdata = {`SPC_RD_PAD, r_r.pcon};
      end else if (idx == `SPC_IDX_SERIAL_CONTROL) begin
        // Top bit shows the error flag only while view select is set
        r_nxt.prdata = {`SPC_RD_PAD, r_r.pcon[`SPC_PC_FE_VIEW] ? r_r.fe : r_r.scon[7], r_r.scon[6:0]}; // see R02
      end else if (idx == `SPC_IDX_SERIAL_BUFFER) begin
        r_nxt.prdata = {`SPC_RD_PAD, r_r.rxbuf}; // see R11
      end else if (idx == `SPC_IDX_SERIAL_CONFIG) begin
        r_nxt.prdata = {`SPC_RD_PAD, r_r.cfg[7:1], 1'b0};
      end else if (idx == `SPC_IDX_AUX_CONTROL_TWO) begin
        r_nxt.prdata = {`SPC_RD_PAD, r_r.aux};
      end else if (idx == `SPC_IDX_STATION_ADDRESS) begin
        r_nxt.prdata = {`SPC_RD_PAD, r_r.station_address};
      end else if (idx == `SPC_IDX_STATION_ADDRESS_MASK) begin
        r_nxt.prdata = {`SPC_RD_PAD, r_r.station_address_mask};
      end else begin
        r_nxt.pslverr = 1'b1;
      end
    end

    // Register writes at the completing access edge
    if (wr && aligned) begin
      if (idx == `SPC_IDX_POWER_CONTROL) begin
        r_nxt.pcon = wd;
      end else if (idx == `SPC_IDX_SERIAL_CONTROL) begin
        r_nxt.scon[6:0] = wd[6:0];
        // Top bit goes to the error flag or to the mode bit
        if (r_r.pcon[`SPC_PC_FE_VIEW]) begin
          r_nxt.fe = wd[7]; // see R02
        end else begin
          r_nxt.scon[7] = wd[7];
        end
      end else if (idx == `SPC_IDX_SERIAL_CONFIG) begin
        r_nxt.cfg = {wd[7:1], 1'b0};
      end else if (idx == `SPC_IDX_AUX_CONTROL_TWO) begin
        r_nxt.aux = wd;
      end else if (idx == `SPC_IDX_STATION_ADDRESS) begin
        r_nxt.station_address = wd;
      end else if (idx == `SPC_IDX_STATION_ADDRESS_MASK) begin
        r_nxt.station_address_mask = wd;
      end
    end

    // Transmit / shift engine
    case (r_r.tx_st)
      TX_IDLE: begin
        // Buffer write starts a transfer; ignored while busy or reserved
        if (wr && aligned && idx == `SPC_IDX_SERIAL_BUFFER && is_uart) begin
          r_nxt.tx_st = TX_UART;
          r_nxt.tx_frame = {1'b1, is_nine ? r_r.scon[`SPC_SC_TX_NINTH] : 1'b1, tx_ord, 1'b0}; // see R07
          r_nxt.tx_bit = 4'd0;
          r_nxt.tx_ph = 2'd0;
          r_nxt.txd = 1'b0;
        end else if (wr && aligned && idx == `SPC_IDX_SERIAL_BUFFER && is_sync) begin
          r_nxt.tx_st = TX_SYNC;
          r_nxt.tx_frame = {3'b111, tx_ord};
          r_nxt.tx_bit = 4'd0;
          r_nxt.tx_ph = 2'd0;
          r_nxt.sync_rx = 1'b0;
          r_nxt.rxd_oe = 1'b1;
        end else if (mode == `SPC_MODE_SHIFT && r_r.scon[`SPC_SC_RX_EN] && !r_r.scon[`SPC_SC_RX_DONE]) begin
          // Shift-mode reception runs while enabled and the flag is clear
          r_nxt.tx_st = TX_SYNC; // see R06
          r_nxt.tx_bit = 4'd0;
          r_nxt.tx_ph = 2'd0;
          r_nxt.sync_rx = 1'b1;
          r_nxt.rxd_oe = 1'b0;
        end
      end
      TX_UART: begin
        if (tick) begin
          r_nxt.tx_ph = r_r.tx_ph + 2'd1;
          if (r_r.tx_ph == 2'd3) begin
            if (r_r.tx_bit == (is_nine ? `SPC_STOP9_BIT : `SPC_NINTH_BIT)) begin
              r_nxt.tx_st = TX_IDLE;
            end else begin
              r_nxt.tx_frame = {1'b1, r_r.tx_frame[10:1]};
              r_nxt.txd = r_r.tx_frame[1];
              r_nxt.tx_bit = r_r.tx_bit + 4'd1;
              // Flag rises as the stop bit begins
              if (r_r.tx_bit + 4'd1 == (is_nine ? `SPC_STOP9_BIT : `SPC_NINTH_BIT)) begin
                r_nxt.scon[`SPC_SC_TX_DONE] = 1'b1; // see R09
              end
            end
          end
        end
      end
      TX_SYNC: begin
        // Low half drives data, high half samples the input
        if (tick) begin
          if (!r_r.tx_ph[0]) begin
            r_nxt.txd = 1'b0;
            r_nxt.rxd_o = r_r.tx_frame[0];
            r_nxt.tx_ph = 2'd1;
          end else begin
            r_nxt.txd = 1'b1;
            r_nxt.tx_ph = 2'd0;
            r_nxt.rx_sh = sh_new;
            r_nxt.tx_frame = {1'b1, r_r.tx_frame[10:1]};
            r_nxt.tx_bit = r_r.tx_bit + 4'd1;
            if (r_r.tx_bit == `SPC_SYNC_LAST) begin
              // End of the eighth bit time
              r_nxt.tx_st = TX_IDLE;
              r_nxt.rxd_oe = 1'b0;
              if (r_r.sync_rx) begin
                r_nxt.scon[`SPC_SC_RX_DONE] = 1'b1; // see R10
                r_nxt.rxbuf = sh_new; // see R11
              end else begin
                r_nxt.scon[`SPC_SC_TX_DONE] = 1'b1; // see R09
                // SPI returns MISO data without a receive flag
                if (mode == `SPC_MODE_SPI) begin
                  r_nxt.rxbuf = sh_new;
                end
              end
            end
          end
        end
      end
      default: begin
        r_nxt.tx_st = TX_IDLE;
      end
    endcase

    // UART receive engine
    case (r_r.rx_st)
      RX_IDLE: begin
        // Start edge is only honoured while reception is enabled
        if (tick && is_uart && r_r.scon[`SPC_SC_RX_EN] && !rxd_i) begin // see R06
          r_nxt.rx_st = RX_BUSY;
          r_nxt.rx_bit = `SPC_START_BIT;
          r_nxt.rx_ph = 2'd0;
        end
      end
      RX_BUSY: begin
        if (!is_uart || !r_r.scon[`SPC_SC_RX_EN]) begin
          r_nxt.rx_st = RX_IDLE; // see R06
        end else if (tick) begin
          r_nxt.rx_ph = r_r.rx_ph + 2'd1;
          if (r_r.rx_ph == `SPC_SAMPLE_PHASE) begin
            r_nxt.rx_bit = r_r.rx_bit + 4'd1;
            if (r_r.rx_bit == `SPC_START_BIT) begin
              // A high start sample is noise: drop it
              if (rxd_i) begin
                r_nxt.rx_st = RX_IDLE;
              end
            end else if (r_r.rx_bit <= `SPC_LAST_DATA_BIT) begin
              r_nxt.rx_sh = sh_new;
            end else if (r_r.rx_bit == `SPC_NINTH_BIT && is_nine) begin
              r_nxt.rx_n9 = rxd_i;
            end else begin
              // Halfway through the stop bit
              r_nxt.rx_st = RX_IDLE;
              if (!stop_ok) begin
                r_nxt.fe = 1'b1; // see R02, R03
              end
              // A pending unread frame is kept, the new one is lost
              if (accept && !r_r.scon[`SPC_SC_RX_DONE]) begin
                r_nxt.scon[`SPC_SC_RX_DONE] = 1'b1; // see R10
                r_nxt.rxbuf = r_r.rx_sh; // see R11
                r_nxt.scon[`SPC_SC_RX_NINTH] = is_nine ? r_r.rx_n9 : stop_ok; // see R08
              end
            end
          end
        end
      end
      default: begin
        r_nxt.rx_st = RX_IDLE;
      end
    endcase

    // Interrupt routing from the updated flags
    r_nxt.ser_irq = r_nxt.scon[`SPC_SC_RX_DONE]
      || (r_nxt.scon[`SPC_SC_TX_DONE] && !r_nxt.cfg[`SPC_CF_TX_IRQ_BLOCK]); // see R20
    r_nxt.sys_irq = r_nxt.scon[`SPC_SC_TX_DONE] && r_nxt.cfg[`SPC_CF_TX_IRQ_SHARE]; // see R21
    r_nxt.t1_fast = r_nxt.aux[`SPC_AX_T1_FAST]; // see R22
  end

  // State register; line outputs idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
      r_r.pcon <= `SPC_RST_POWER_CONTROL;
      r_r.scon <= `SPC_RST_SERIAL_CONTROL;
      r_r.cfg <= `SPC_RST_SERIAL_CONFIG; // see R19
      r_r.aux <= `SPC_RST_AUX_CONTROL_TWO;
      r_r.station_address <= `SPC_RST_STATION_ADDRESS; // see R14
      r_r.station_address_mask <= `SPC_RST_STATION_ADDRESS_MASK; // see R14
      r_r.rxbuf <= `SPC_RST_SERIAL_BUFFER;
      r_r.tx_st <= TX_IDLE;
      r_r.rx_st <= RX_IDLE;
      r_r.txd <= 1'b1;
      r_r.rxd_o <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign txd_o = r_r.txd;
  assign rxd_o = r_r.rxd_o;
  assign rxd_oe = r_r.rxd_oe;
  assign serial_irq = r_r.ser_irq;
  assign sysflag_irq = r_r.sys_irq;
  assign timer1_fast_clock = r_r.t1_fast;

endmodule : spc_serial_port0_control

// ### tb/spc_monitor.sv
// Checker on the top ports of the serial port 0 control block.
// Assumes: bound to the top module; one clock, async active-low reset.
`timescale 1ns/100ps

module spc_monitor
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial and interrupt outputs
  input wire logic txd_o,
  input wire logic serial_irq,
  input wire logic sysflag_irq,
  input wire logic timer1_fast_clock
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic t1_want_r; // Last value written to the fast-clock field
  logic wr_aux; // Aux register write lands at this edge
  logic mapped; // Address hits one of the seven registers

  assign wr_aux = psel && penable && pready && pwrite && paddr == 12'h28C;
  assign mapped = paddr inside {12'h21C, 12'h260, 12'h264, 12'h270, 12'h28C, 12'h2A4, 12'h2E4};

  // Shadow of the fast-clock field, kept from bus writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_want_r <= 1'b0;
    end else if (wr_aux) begin
      t1_want_r <= pwdata[3];
    end
  end

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  a_fast_copy: assert property (wr_aux |=> ##1 timer1_fast_clock == t1_want_r)
    else $error("fast clock output not following write");
  a_reset_quiet: assert property ($rose(presetn) |-> txd_o && !serial_irq && !sysflag_irq)
    else $error("outputs not idle after reset");

  // Main scenarios reached
  cover property (wr_aux);
  cover property (pready && pslverr);
  cover property ($rose(sysflag_irq));
  cover property ($rose(serial_irq));
endmodule : spc_monitor

bind spc_serial_port0_control spc_monitor i_spc_monitor (.*);

// ### tb/spc_peer.sv
// Remote serial peer: sends UART frames into the block and captures
// frames and shift-clock periods from its transmit line.
// Assumes: bit periods given in pclk cycles; line idles high.
`timescale 1ns/100ps

module spc_peer (
  // Clock
  input wire logic pclk,
  // Line from the block
  input wire logic txd_o,
  // Line into the block
  output logic rxd_i
);
  // Idle level between frames
  initial rxd_i = 1'b1;

  // Start, eight data LSB first, ninth, stop
  task automatic send(input logic [7:0] b, input logic n9, input logic stp, input int per);
    logic [10:0] f;
    f = {stp, n9, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_i <= f[i];
      repeat (per) @(posedge pclk);
    end
    rxd_i <= 1'b1;
  endtask : send

  // Samples mid-bit; tolerates a tick of phase at frame start
  task automatic catch(input int per, output logic [8:0] d);
    @(negedge txd_o);
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < 9; i++) begin
      repeat (per) @(posedge pclk);
      d[i] = txd_o;
    end
  endtask : catch

  // Shift clock period, falling edge to falling edge, in cycles
  task automatic period(output int n);
    realtime t;
    @(negedge txd_o);
    t = $realtime;
    @(negedge txd_o);
    n = int'(($realtime - t) / 8.0);
  endtask : period
endmodule : spc_peer

// ### tb/testbench.sv
// Self-checking bench: registers, transmit, receive,
// framing error, address filter and interrupt routing.
// Assumes: design and package compiled first; monitor bound.
`timescale 1ns/100ps

module testbench;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic timer1_ovf, alt_timer_ovf, txd_o, rxd_i, rxd_o, rxd_oe;
  logic serial_irq, sysflag_irq, timer1_fast_clock;
  wire logic miso_i;
  logic [1:0] ovf_cnt = 2'd0; // Overflow pacing counter
  int failures, samples_checked;
  // Register indices; byte address is four times these
  localparam logic [7:0] I_PWR = 8'h87, I_CTL = 8'h98, I_BUF = 8'h99, I_CFG = 8'h9C;
  localparam logic [7:0] I_AUX = 8'hA3, I_SAD = 8'hA9, I_MSK = 8'hB9;
  // Transmit cases: control, config, power, bit period, frame seen
  localparam logic [7:0] TCTL [7] = '{8'h88, 8'h80, 8'h88, 8'h80, 8'hC8, 8'h40, 8'h80};
  localparam logic [7:0] TCFG [7] = '{8'h08, 8'h08, 8'h48, 8'h48, 8'h08, 8'h88, 8'h00};
  localparam logic [7:0] TPWR [7] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  localparam int TPER [7] = '{64, 32, 16, 8, 64, 128, 64};
  localparam logic [8:0] TEXP [7] = '{9'h13A, 9'h03A, 9'h13A, 9'h03A, 9'h13A, 9'h13A, 9'h05C};
  // Filter cases: control, byte, ninth, control read back
  localparam logic [7:0] FCTL [5] = '{8'hB0, 8'hB0, 8'hB0, 8'hB0, 8'h70};
  localparam logic [7:0] FBYT [5] = '{8'hC2, 8'h55, 8'hFD, 8'hC0, 8'hC2};
  localparam logic [4:0] FN9 = 5'b00111;
  localparam logic [7:0] FEXP [5] = '{8'hB5, 8'hB0, 8'hB5, 8'hB0, 8'h70};

  // SPI loopback keeps the mode 4 input moving
  assign miso_i = rxd_o;

  spc_serial_port0_control i_spc_serial_port0_control (.*);
  spc_peer i_spc_peer (.*);

  // Clock, 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Timer 1 overflows every 2 cycles, alternate timer every 4
  always @(posedge pclk) begin
    ovf_cnt <= ovf_cnt + 2'd1;
    timer1_ovf <= ovf_cnt[0];
    alt_timer_ovf <= ovf_cnt == 2'd3;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer, then an idle edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [8:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= 32'(wd);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = {pslverr, prdata[7:0]};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [8:0] r;
    apb(1'b1, idx, d, r);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [8:0] exp);
    logic [8:0] r;
    apb(1'b0, idx, 8'h00, r);
    check(nm, r, exp);
  endtask : rd_chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, over three times the expected run
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    logic [8:0] got;
    int n;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, then a refused index
    rd_chk("power", I_PWR, 9'h000);
    rd_chk("control", I_CTL, 9'h000);
    rd_chk("config", I_CFG, 9'h008);
    rd_chk("address", I_SAD, 9'h000);
    rd_chk("mask", I_MSK, 9'h000);
    rd_chk("unmapped", 8'h00, 9'h100);
    wr(I_AUX, 8'h08);
    rd_chk("aux", I_AUX, 9'h008);
    check("fast clock", timer1_fast_clock, 1'b1);
    // Transmit across modes, rates, bit order
    for (int i = 0; i < 7; i++) begin
      wr(I_PWR, TPWR[i]);
      wr(I_CFG, TCFG[i]);
      wr(I_CTL, TCTL[i]);
      fork
        i_spc_peer.catch(TPER[i], got);
        wr(I_BUF, 8'h3A);
      join
      check("tx frame", got, TEXP[i]);
      repeat (2 * TPER[i]) @(posedge pclk);
      rd_chk("tx done", I_CTL, {1'b0, TCTL[i] | 8'h02});
    end
    // Transmit flag routing
    check("serial irq", serial_irq, 1'b1);
    check("sysflag irq", sysflag_irq, 1'b0);
    wr(I_CFG, 8'h0E);
    @(posedge pclk);
    check("blocked irq", serial_irq, 1'b0);
    check("shared irq", sysflag_irq, 1'b1);
    // Shift modes 0 and 4 at both rates
    for (int j = 0; j < 4; j++) begin
      wr(I_CFG, {2'b00, j[0], j[1], 4'h8});
      wr(I_CTL, 8'h00);
      fork
        i_spc_peer.period(n);
        wr(I_BUF, 8'hC3);
      join
      check("shift period", n, j[0] ? 4 : 12);
      repeat (120) @(posedge pclk);
      rd_chk("shift done", I_CTL, 9'h002);
      rd_chk("spi data", I_BUF, j[1] ? 9'h0C3 : 9'h000);
    end
    // Mode 2 receive
    wr(I_CFG, 8'h08);
    wr(I_CTL, 8'h90);
    i_spc_peer.send(8'h5B, 1'b1, 1'b1, 64);
    rd_chk("rx flags", I_CTL, 9'h095);
    rd_chk("rx data", I_BUF, 9'h05B);
    // Reception off
    wr(I_CTL, 8'h80);
    i_spc_peer.send(8'h77, 1'b1, 1'b1, 64);
    rd_chk("rx off", I_CTL, 9'h080);
    // Mode 1 bad stop, view hidden then shown
    wr(I_CTL, 8'h50);
    i_spc_peer.send(8'h11, 1'b0, 1'b1, 64);
    rd_chk("stop kept", I_CTL, 9'h051);
    wr(I_PWR, 8'h40);
    rd_chk("frame error", I_CTL, 9'h0D1);
    wr(I_CTL, 8'hD0);
    i_spc_peer.send(8'h22, 1'b1, 1'b1, 64);
    rd_chk("error sticky", I_CTL, 9'h0D5);
    wr(I_CTL, 8'h50);
    rd_chk("error cleared", I_CTL, 9'h050);
    wr(I_PWR, 8'h00);
    // Address filter: given, miss, broadcast, data byte, bad stop
    wr(I_SAD, 8'hC0);
    wr(I_MSK, 8'hFD);
    for (int k = 0; k < 5; k++) begin
      wr(I_CTL, FCTL[k]);
      i_spc_peer.send(FBYT[k], FN9[k], 1'b1, 64);
      rd_chk("addr filter", I_CTL, {1'b0, FEXP[k]});
    end
    tally_and_finish();
  end
endmodule : testbench
